/* rtl/ptdp_params.svh */
// Purpose: Constants of the page-table data pipe engine.
// Assumes: Register offsets are byte addresses on the plain register port.
// Notes: Included by the engine, the remote node model and the bench.
//
// How it works
// - Page-table mode when table flag is 1 and page size nonzero; page limit whenever page size is nonzero.
// - No generated packet runs past the page end while page size is nonzero.
// - One element per start; software loads length, base and offset first.
// - Writing 1 to the go bit starts the transfer.
// - With page size 0, full max-payload packets follow each other, then one packet for the rest.
// - Speed field 0 sends at S100, 1 at S200.
// - No packet payload exceeds 2^(max_payload+2) bytes.
// - Direction 1 builds quadlet and block write requests and sends them.
// - A busy acknowledge is retried as the busy-timeout field allows.
// - A missing response reports timeout after the split-timeout interval.
// - Direction 0 builds quadlet and block read requests and sends them.
// - Read response data goes to the async receive buffer.
// - Four-bit transaction code: 0 quadlet write, 1 block write.
// - Page length is 2^(page_size+8) bytes.
`ifndef PTDP_PARAMS_SVH
`define PTDP_PARAMS_SVH

// ****************************************
// Register map and reset values
// ****************************************
`define PTDP_A_XFER 8'h00
`define PTDP_A_CTRL 8'h04
`define PTDP_A_DEST 8'h08
`define PTDP_A_OFFHI 8'h0c
`define PTDP_A_OFFLO 8'h10
`define PTDP_A_CMD 8'h14
`define PTDP_A_STAT 8'h18
`define PTDP_A_ISTAT 8'h1c
`define PTDP_A_IMASK 8'h20
`define PTDP_CMD_GO 0
`define PTDP_RST_W32 32'h0000_0000
`define PTDP_RST_W16 16'h0000

// ****************************************
// Packet codes
// ****************************************
`define PTDP_TC_QWR 4'h0
`define PTDP_TC_BWR 4'h1
`define PTDP_TC_QRD 4'h4
`define PTDP_TC_BRD 4'h5
`define PTDP_ACK_COMPLETE 4'h1
`define PTDP_ACK_PENDING 4'h2
`define PTDP_ACK_BUSY_X 4'h4
`define PTDP_ACK_BUSY_A 4'h5
`define PTDP_ACK_BUSY_B 4'h6
`define PTDP_RCODE_OK 4'h0
`define PTDP_RT_FIRST 2'h0
`define PTDP_RT_RETRY 2'h1
`define PTDP_QUAD_BYTES 18'h00004
`define PTDP_PAY_BASE 5'h02
`define PTDP_PAGE_BASE 5'h08

// ****************************************
// Timing
// ****************************************
`define PTDP_CLK_NS 10
`define PTDP_SPLIT_UNIT_NS 1000
`define PTDP_SPLIT_UNIT_CYC ((`PTDP_SPLIT_UNIT_NS + `PTDP_CLK_NS - 1) / `PTDP_CLK_NS)

`endif

/* rtl/ptdp_pkg.sv */
// Purpose: Types of the page-table data pipe engine.
// Assumes: Field layouts are fixed by these packed structs.
// Notes: Numbers live in ptdp_params.svh.
package ptdp_pkg;
    typedef struct packed {
        logic d;
        logic [2:0] sp;
        logic [3:0] max_payload;
        logic [3:0] rsvd;
        logic p;
        logic [2:0] page_size;
        logic [15:0] xfer_length;
    } ptdp_xfer_t;

    typedef struct packed {
        logic [15:0] split_timeout;
        logic [11:0] rsvd;
        logic [3:0] busy_timeout;
    } ptdp_ctrl_t;

    typedef struct packed {
        logic err;
        logic tmo;
        logic rfail;
        logic done;
    } ptdp_evt_t;

    typedef struct packed {
        logic [15:0] remaining;
        logic [10:0] rsvd;
        logic busy;
        ptdp_evt_t last;
    } ptdp_stat_t;

    typedef struct packed {
        logic [3:0] tcode;
        logic [2:0] speed;
        logic [1:0] retry;
        logic [15:0] dest_id;
        logic [15:0] off_hi;
        logic [31:0] off_lo;
        logic [15:0] length;
    } ptdp_req_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CALC, ST_SEND, ST_ACK, ST_RESP, ST_NEXT
    } ptdp_state_t;
endpackage : ptdp_pkg

/* rtl/ptdp_top.sv */
// Purpose: Page-table data pipe engine, one page-table element per start.
// Assumes: Link side takes a request on REQ_VALID and REQ_READY both high.
// Notes: Write payload data comes from the data FIFO, outside this block.
`timescale 1ns/100ps
`include "ptdp_params.svh"

module ptdp_top #(
    parameter int SPLIT_UNIT_CYC = `PTDP_SPLIT_UNIT_CYC
) (
    input wire logic CORE_CLK, // System clock
    input wire logic SRST, // Synchronous reset
    input wire logic [7:0] REG_ADDR, // Register byte address
    input wire logic [31:0] REG_WDATA, // Register write data
    input wire logic REG_WR, // Write strobe
    input wire logic REG_RD, // Read strobe
    output logic [31:0] REG_RDATA, // Read data, cycle after strobe
    output logic REQ_VALID, // Request packet offered
    output ptdp_pkg::ptdp_req_t REQ_PKT, // Request packet header
    input wire logic REQ_READY, // Link takes the request
    input wire logic ACK_VALID, // Acknowledge received
    input wire logic [3:0] ACK_CODE, // Acknowledge code
    input wire logic RESP_VALID, // Response packet received
    input wire logic [3:0] RESP_RCODE, // Response code
    input wire logic RX_VALID, // Response data quadlet
    input wire logic [31:0] RX_DATA, // Response data
    output logic ARB_WE, // Async receive buffer write
    output logic [31:0] ARB_WDATA, // Async receive buffer data
    output logic IRQ // Level interrupt
);

    // ****************************************
    // Register port
    // ****************************************
    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    ptdp_pkg::ptdp_xfer_t xfer_q;
    ptdp_pkg::ptdp_ctrl_t ctrl_q;
    logic [15:0] dest_q;
    logic [15:0] offhi_q;
    logic [31:0] offlo_q;
    ptdp_pkg::ptdp_evt_t last_q, last_d;
    ptdp_pkg::ptdp_evt_t istat_q, istat_d;
    ptdp_pkg::ptdp_evt_t imask_q;
    ptdp_pkg::ptdp_evt_t evt;
    ptdp_pkg::ptdp_stat_t stat;
    ptdp_pkg::ptdp_state_t st_q, st_d;
    logic [31:0] rdata_d;
    logic [15:0] rem_q;

    wire wr_xfer = REG_WR && hit(REG_ADDR, `PTDP_A_XFER);
    wire wr_ctrl = REG_WR && hit(REG_ADDR, `PTDP_A_CTRL);
    wire wr_dest = REG_WR && hit(REG_ADDR, `PTDP_A_DEST);
    wire wr_offhi = REG_WR && hit(REG_ADDR, `PTDP_A_OFFHI);
    wire wr_offlo = REG_WR && hit(REG_ADDR, `PTDP_A_OFFLO);
    wire wr_imask = REG_WR && hit(REG_ADDR, `PTDP_A_IMASK);
    wire rd_istat = REG_RD && hit(REG_ADDR, `PTDP_A_ISTAT);
    // Go while busy is ignored so a running element is never restarted
    wire go_hit = REG_WR && hit(REG_ADDR, `PTDP_A_CMD) && REG_WDATA[`PTDP_CMD_GO]
        && (st_q == ptdp_pkg::ST_IDLE);

    assign stat = '{remaining: rem_q, rsvd: '0, busy: (st_q != ptdp_pkg::ST_IDLE),
        last: last_q};

    always_comb begin
        rdata_d = `PTDP_RST_W32;
        if (REG_RD) begin
            unique case (1'b1)
                hit(REG_ADDR, `PTDP_A_XFER): rdata_d = xfer_q;
                hit(REG_ADDR, `PTDP_A_CTRL): rdata_d = ctrl_q;
                hit(REG_ADDR, `PTDP_A_DEST): rdata_d = {`PTDP_RST_W16, dest_q};
                hit(REG_ADDR, `PTDP_A_OFFHI): rdata_d = {`PTDP_RST_W16, offhi_q};
                hit(REG_ADDR, `PTDP_A_OFFLO): rdata_d = offlo_q;
                hit(REG_ADDR, `PTDP_A_STAT): rdata_d = stat;
                hit(REG_ADDR, `PTDP_A_ISTAT): rdata_d = {28'h0000000, istat_q};
                hit(REG_ADDR, `PTDP_A_IMASK): rdata_d = {28'h0000000, imask_q};
                default: rdata_d = `PTDP_RST_W32;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            xfer_q <= `PTDP_RST_W32;
            ctrl_q <= `PTDP_RST_W32;
            dest_q <= `PTDP_RST_W16;
            offhi_q <= `PTDP_RST_W16;
            offlo_q <= `PTDP_RST_W32;
        end else begin
            if (wr_xfer) xfer_q <= REG_WDATA;
            if (wr_ctrl) ctrl_q <= REG_WDATA;
            if (wr_dest) dest_q <= REG_WDATA[15:0];
            if (wr_offhi) offhi_q <= REG_WDATA[15:0];
            if (wr_offlo) offlo_q <= REG_WDATA;
        end
    end

    // ****************************************
    // Interrupt and status
    // ****************************************
    // Set wins over the read-clear so an event in the read cycle is kept
    assign istat_d = (rd_istat ? 4'h0 : istat_q) | evt;
    assign last_d = (go_hit ? 4'h0 : last_q) | evt;

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            istat_q <= 4'h0;
            imask_q <= 4'h0;
            last_q <= 4'h0;
            IRQ <= 1'b0;
            REG_RDATA <= `PTDP_RST_W32;
        end else begin
            istat_q <= istat_d;
            last_q <= last_d;
            if (wr_imask) imask_q <= REG_WDATA[3:0];
            IRQ <= |(istat_d & (wr_imask ? REG_WDATA[3:0] : imask_q));
            REG_RDATA <= rdata_d;
        end
    end

    // ****************************************
    // Packet sizing
    // ****************************************
    logic [47:0] addr_q;
    logic [17:0] chunk_q;
    logic [3:0] retry_q;
    logic [15:0] tick_q;
    logic [15:0] unit_q;

    wire page_mode = xfer_q.p && (xfer_q.page_size != 3'h0);
    wire page_lim = xfer_q.page_size != 3'h0;
    wire [4:0] pay_sh = {1'b0, xfer_q.max_payload} + `PTDP_PAY_BASE;
    wire [17:0] pay_bytes = 18'h00001 << pay_sh;
    wire [4:0] page_sh = {2'h0, xfer_q.page_size} + `PTDP_PAGE_BASE;
    wire [17:0] page_bytes = 18'h00001 << page_sh;
    wire [17:0] page_off = addr_q[17:0] & (page_bytes - 18'h00001);
    wire [17:0] to_end = page_bytes - page_off;
    wire [17:0] rem18 = {2'h0, rem_q};
    // Full payload while enough remains, the rest in the last packet
    wire [17:0] lim1 = (pay_bytes < rem18) ? pay_bytes : rem18;
    wire [17:0] chunk = (page_lim && (to_end < lim1)) ? to_end : lim1;
    wire quad = (chunk == `PTDP_QUAD_BYTES) && (addr_q[1:0] == 2'h0);
    wire [3:0] tc_wr = quad ? `PTDP_TC_QWR : `PTDP_TC_BWR;
    wire [3:0] tc_rd = quad ? `PTDP_TC_QRD : `PTDP_TC_BRD;
    wire last_pkt = (rem18 == chunk_q);

    // ****************************************
    // Transaction control
    // ****************************************
    wire ack_ok = ACK_CODE == `PTDP_ACK_COMPLETE;
    wire ack_pend = ACK_CODE == `PTDP_ACK_PENDING;
    wire ack_busy = (ACK_CODE == `PTDP_ACK_BUSY_X) || (ACK_CODE == `PTDP_ACK_BUSY_A)
        || (ACK_CODE == `PTDP_ACK_BUSY_B);
    wire can_retry = retry_q < ctrl_q.busy_timeout;
    wire in_wait = (st_q == ptdp_pkg::ST_ACK) || (st_q == ptdp_pkg::ST_RESP);
    wire tmo = unit_q >= ctrl_q.split_timeout;
    wire unit_end = tick_q == 16'(SPLIT_UNIT_CYC - 1);
    wire tmr_run = in_wait && (st_d == st_q);
    wire do_retry = (st_q == ptdp_pkg::ST_ACK) && ACK_VALID && ack_busy && can_retry;

    always_comb begin
        st_d = st_q;
        evt = 4'h0;
        unique case (st_q)
            ptdp_pkg::ST_IDLE: begin
                if (go_hit && (xfer_q.xfer_length == `PTDP_RST_W16)) begin
                    evt.done = 1'b1;
                end else if (go_hit) begin
                    st_d = ptdp_pkg::ST_CALC;
                end
            end
            ptdp_pkg::ST_CALC: st_d = ptdp_pkg::ST_SEND;
            ptdp_pkg::ST_SEND: begin
                if (REQ_READY) st_d = ptdp_pkg::ST_ACK;
            end
            ptdp_pkg::ST_ACK: begin
                if (ACK_VALID) begin
                    if (ack_ok) begin
                        st_d = ptdp_pkg::ST_NEXT;
                    end else if (ack_pend) begin
                        st_d = ptdp_pkg::ST_RESP;
                    end else if (ack_busy && can_retry) begin
                        st_d = ptdp_pkg::ST_SEND;
                    end else if (ack_busy) begin
                        st_d = ptdp_pkg::ST_IDLE;
                        evt.rfail = 1'b1;
                    end else begin
                        st_d = ptdp_pkg::ST_IDLE;
                        evt.err = 1'b1;
                    end
                end else if (tmo) begin
                    st_d = ptdp_pkg::ST_IDLE;
                    evt.tmo = 1'b1;
                end
            end
            ptdp_pkg::ST_RESP: begin
                if (RESP_VALID && (RESP_RCODE == `PTDP_RCODE_OK)) begin
                    st_d = ptdp_pkg::ST_NEXT;
                end else if (RESP_VALID) begin
                    st_d = ptdp_pkg::ST_IDLE;
                    evt.err = 1'b1;
                end else if (tmo) begin
                    st_d = ptdp_pkg::ST_IDLE;
                    evt.tmo = 1'b1;
                end
            end
            ptdp_pkg::ST_NEXT: begin
                st_d = last_pkt ? ptdp_pkg::ST_IDLE : ptdp_pkg::ST_CALC;
                evt.done = last_pkt;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) st_q <= ptdp_pkg::ST_IDLE;
        else st_q <= st_d;
    end

    // Working address and count; the software offsets stay as loaded
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            addr_q <= 48'h0;
            rem_q <= `PTDP_RST_W16;
            chunk_q <= 18'h0;
        end else if (go_hit) begin
            addr_q <= {offhi_q, offlo_q};
            rem_q <= xfer_q.xfer_length;
        end else if (st_q == ptdp_pkg::ST_CALC) begin
            chunk_q <= chunk;
        end else if (st_q == ptdp_pkg::ST_NEXT) begin
            addr_q <= addr_q + {30'h0, chunk_q};
            rem_q <= rem_q - chunk_q[15:0];
        end
    end

    // Split timer counts whole units so long timeouts need few bits
    always_ff @(posedge CORE_CLK) begin
        if (SRST || !tmr_run) begin
            tick_q <= `PTDP_RST_W16;
            unit_q <= `PTDP_RST_W16;
        end else if (unit_end) begin
            tick_q <= `PTDP_RST_W16;
            unit_q <= tmo ? unit_q : unit_q + 16'h0001;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST || (st_q == ptdp_pkg::ST_CALC)) retry_q <= 4'h0;
        else if (do_retry) retry_q <= retry_q + 4'h1;
    end

    // ****************************************
    // Request packet and receive buffer
    // ****************************************
    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            REQ_VALID <= 1'b0;
            REQ_PKT <= '0;
        end else begin
            REQ_VALID <= (st_d == ptdp_pkg::ST_SEND);
            if (st_q == ptdp_pkg::ST_CALC) begin
                REQ_PKT.tcode <= xfer_q.d ? tc_wr : tc_rd;
                REQ_PKT.speed <= xfer_q.sp;
                REQ_PKT.retry <= `PTDP_RT_FIRST;
                REQ_PKT.dest_id <= dest_q;
                REQ_PKT.off_hi <= addr_q[47:32];
                REQ_PKT.off_lo <= addr_q[31:0];
                REQ_PKT.length <= chunk[15:0];
            end else if (do_retry) begin
                REQ_PKT.retry <= `PTDP_RT_RETRY;
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (SRST) begin
            ARB_WE <= 1'b0;
            ARB_WDATA <= `PTDP_RST_W32;
        end else begin
            ARB_WE <= RX_VALID && (st_q == ptdp_pkg::ST_RESP) && !xfer_q.d;
            ARB_WDATA <= RX_DATA;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence go_seq;
        go_hit && (xfer_q.xfer_length != `PTDP_RST_W16);
    endsequence

    sequence send_seq;
        ##2 REQ_VALID && (REQ_PKT.retry == `PTDP_RT_FIRST);
    endsequence

    go_start_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        go_seq |-> send_seq) else $error("go did not raise a request");
    pay_max_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        REQ_VALID |-> {2'h0, REQ_PKT.length} <= pay_bytes) else $error("payload too big");
    page_end_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        REQ_VALID && page_lim |-> ({2'h0, REQ_PKT.length} + (REQ_PKT.off_lo[17:0]
        & (page_bytes - 18'h00001))) <= page_bytes) else $error("packet crosses page");
    wr_code_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        REQ_VALID && xfer_q.d |-> (REQ_PKT.tcode == `PTDP_TC_QWR)
        || (REQ_PKT.tcode == `PTDP_TC_BWR)) else $error("bad write code");
    rd_code_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        REQ_VALID && !xfer_q.d |-> (REQ_PKT.tcode == `PTDP_TC_QRD)
        || (REQ_PKT.tcode == `PTDP_TC_BRD)) else $error("bad read code");
    req_speed_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        REQ_VALID |-> REQ_PKT.speed == xfer_q.sp) else $error("wrong speed");
    busy_retry_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        do_retry |=> REQ_VALID && (REQ_PKT.retry == `PTDP_RT_RETRY)
        && $stable(REQ_PKT.off_lo)) else $error("busy not retried");
    split_tmo_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (st_q == ptdp_pkg::ST_RESP) && !RESP_VALID && tmo
        |=> istat_q.tmo && (st_q == ptdp_pkg::ST_IDLE)) else $error("timeout lost");
    arb_fwd_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        RX_VALID && (st_q == ptdp_pkg::ST_RESP) && !xfer_q.d
        |=> ARB_WE && (ARB_WDATA == $past(RX_DATA))) else $error("data not buffered");
    elem_done_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        (st_q == ptdp_pkg::ST_NEXT) && last_pkt |=> last_q.done && (rem_q == 16'h0000)
        && istat_q.done) else $error("done not shown");
    page_mode_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        REQ_VALID && page_mode |-> {2'h0, REQ_PKT.length} <= to_end) else $error("page mode limit");
    req_hold_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        REQ_VALID && !REQ_READY |=> REQ_VALID && $stable(REQ_PKT))
        else $error("request dropped");
    quad_code_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        REQ_VALID && xfer_q.d && ({2'h0, REQ_PKT.length} == `PTDP_QUAD_BYTES)
        && (REQ_PKT.off_lo[1:0] == 2'h0) |-> REQ_PKT.tcode == `PTDP_TC_QWR) else $error("quad code");

    // Retries used up end the element
    sequence busy_out_seq;
        (st_q == ptdp_pkg::ST_ACK) && ACK_VALID && ack_busy && !can_retry;
    endsequence

    busy_fail_a: assert property (@(posedge CORE_CLK) disable iff (SRST)
        busy_out_seq |=> last_q.rfail && (st_q == ptdp_pkg::ST_IDLE))
        else $error("retry limit lost");

endmodule : ptdp_top

/* bench/ptdp_remote_node.sv */
// Purpose: Remote responder node model answering generated request packets.
// Assumes: mode 0 complete, 1 pending plus response, 2 busy, 3 pending and silent.
// Notes: Released answer lines show the inverse of their last value.
`timescale 1ns/100ps
`include "ptdp_params.svh"

module ptdp_remote_node (
    input wire logic clk, // Core clock
    input wire logic srst, // Reset, keeps the node quiet
    input wire logic [1:0] mode, // Answer style chosen by the bench
    input wire logic slow, // Hold off the take for three cycles
    input wire logic req_valid, // Request offered
    input wire ptdp_pkg::ptdp_req_t req_pkt, // Request header
    output logic req_ready, // Request taken
    output logic ack_valid, // Acknowledge pulse
    output logic [3:0] ack_code, // Acknowledge code
    output logic resp_valid, // Response packet pulse
    output logic [3:0] resp_rcode, // Response code
    output logic rx_valid, // Response data quadlet pulse
    output logic [31:0] rx_data // Response data
);
    ptdp_pkg::ptdp_req_t pkt;
    logic [3:0] code;
    int n;
    int seq;

    initial begin
        req_ready = 1'b0;
        ack_valid = 1'b0;
        ack_code = 4'h0;
        resp_valid = 1'b0;
        resp_rcode = 4'hf;
        rx_valid = 1'b0;
        rx_data = 32'h00000000;
        seq = 0;
        forever begin
            @(posedge clk);
            if (req_valid && !srst) begin
                if (slow) repeat (3) @(posedge clk);
                req_ready <= 1'b1;
                @(posedge clk);
                pkt = req_pkt;
                req_ready <= 1'b0;
                code = (mode == 2'h0) ? `PTDP_ACK_COMPLETE :
                       (mode == 2'h2) ? `PTDP_ACK_BUSY_A : `PTDP_ACK_PENDING;
                repeat (2) @(posedge clk);
                ack_valid <= 1'b1;
                ack_code <= code;
                @(posedge clk);
                ack_valid <= 1'b0;
                ack_code <= ~code;
                if (mode == 2'h1) begin
                    repeat (2) @(posedge clk);
                    // Read data goes ahead of the response that closes it
                    for (n = 0; pkt.tcode[2] && n < int'(pkt.length[15:2]); n++) begin
                        rx_valid <= 1'b1;
                        rx_data <= 32'hc0de0000 + 32'(seq);
                        seq++;
                        @(posedge clk);
                    end
                    rx_valid <= 1'b0;
                    rx_data <= ~rx_data;
                    resp_valid <= 1'b1;
                    resp_rcode <= `PTDP_RCODE_OK;
                    @(posedge clk);
                    resp_valid <= 1'b0;
                    resp_rcode <= ~resp_rcode;
                end
            end
        end
    end
endmodule : ptdp_remote_node

/* bench/ptdp_top_bench.sv */
// Purpose: Self-checking bench of the page-table data pipe engine.
// Assumes: SPLIT_UNIT_CYC set to 2 so split timeouts stay short.
// Notes: Packets are logged at each take and judged after the element ends.
`timescale 1ns/100ps
`include "ptdp_params.svh"

module ptdp_top_bench;
    logic CORE_CLK = 1'b0;
    logic SRST = 1'b1;
    logic [7:0] REG_ADDR = 8'h00;
    logic [31:0] REG_WDATA = 32'h00000000;
    logic REG_WR = 1'b0;
    logic REG_RD = 1'b0;
    logic [31:0] REG_RDATA, RX_DATA, ARB_WDATA, arb_last;
    logic REQ_VALID, REQ_READY, ACK_VALID, RESP_VALID, RX_VALID, ARB_WE, IRQ;
    logic [3:0] ACK_CODE, RESP_RCODE;
    ptdp_pkg::ptdp_req_t REQ_PKT;
    ptdp_pkg::ptdp_req_t seen_q[$];
    logic [1:0] pmode = 2'h0;
    logic pslow = 1'b0;
    int err_total = 0;
    int n_compared = 0;
    int n_arb = 0;
    localparam logic [7:0] RST_ADDR [0:6] = '{`PTDP_A_XFER, `PTDP_A_CTRL, `PTDP_A_STAT,
        `PTDP_A_ISTAT, `PTDP_A_IMASK, `PTDP_A_CMD, 8'h3c};

    always #5 CORE_CLK = ~CORE_CLK;

    ptdp_top #(.SPLIT_UNIT_CYC(2)) dut_u (.CORE_CLK(CORE_CLK), .SRST(SRST),
        .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_RDATA(REG_RDATA), .REQ_VALID(REQ_VALID), .REQ_PKT(REQ_PKT),
        .REQ_READY(REQ_READY), .ACK_VALID(ACK_VALID), .ACK_CODE(ACK_CODE),
        .RESP_VALID(RESP_VALID), .RESP_RCODE(RESP_RCODE), .RX_VALID(RX_VALID),
        .RX_DATA(RX_DATA), .ARB_WE(ARB_WE), .ARB_WDATA(ARB_WDATA), .IRQ(IRQ));

    ptdp_remote_node peer_u (.clk(CORE_CLK), .srst(SRST), .mode(pmode), .slow(pslow),
        .req_valid(REQ_VALID), .req_pkt(REQ_PKT), .req_ready(REQ_READY),
        .ack_valid(ACK_VALID), .ack_code(ACK_CODE), .resp_valid(RESP_VALID),
        .resp_rcode(RESP_RCODE), .rx_valid(RX_VALID), .rx_data(RX_DATA));

    // ****************************************
    // Monitors and shared tasks
    // ****************************************
    always @(posedge CORE_CLK) begin
        if (REQ_VALID && REQ_READY) seen_q.push_back(REQ_PKT);
        if (ARB_WE) begin
            n_arb++;
            arb_last = ARB_WDATA;
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CORE_CLK);
        REG_WR <= 1'b0;
        @(posedge CORE_CLK);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CORE_CLK);
        REG_RD <= 1'b0;
        @(posedge CORE_CLK);
        d = REG_RDATA;
    endtask : reg_rd

    task automatic chk_pkt(input int i, input logic [3:0] tc, input logic [15:0] len,
                           input logic [31:0] off, input logic [2:0] sp, input logic [1:0] rt);
        chk(32'(seen_q[i].tcode), 32'(tc));
        chk(32'(seen_q[i].length), 32'(len));
        chk(seen_q[i].off_lo, off);
        chk(32'(seen_q[i].off_hi), 32'h00000001);
        chk(32'(seen_q[i].speed), 32'(sp));
        chk(32'(seen_q[i].retry), 32'(rt));
        chk(32'(seen_q[i].dest_id), 32'h0000ffc2);
    endtask : chk_pkt

    // One element per start: load the segment, go, then poll until idle
    task automatic run_elem(input logic [31:0] xfer, input logic [31:0] ctrl,
                            input logic [31:0] offlo, input logic [15:0] rem,
                            output logic [31:0] stat);
        seen_q.delete();
        reg_wr(`PTDP_A_DEST, 32'h0000ffc2);
        reg_wr(`PTDP_A_OFFHI, 32'h00000001);
        reg_wr(`PTDP_A_OFFLO, offlo);
        reg_wr(`PTDP_A_CTRL, ctrl);
        reg_wr(`PTDP_A_XFER, xfer);
        reg_wr(`PTDP_A_CMD, 32'h00000001);
        stat = 32'h00000010;
        for (int k = 0; k < 300 && stat[4] !== 1'b0; k++) reg_rd(`PTDP_A_STAT, stat);
        chk(32'(stat[4]), 32'h0);
        chk(32'(stat[31:16]), 32'(rem));
    endtask : run_elem

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [31:0] v;
        chk(32'(IRQ), 32'h0);
        for (int i = 0; i < 7; i++) begin
            reg_rd(RST_ADDR[i], v);
            chk(v, `PTDP_RST_W32);
        end
        $display("test reset values finished");
    endtask : t_reset

    // Quadlet to the page end, then two full payloads from the next page
    task automatic t_write;
        logic [31:0] s;
        pmode = 2'h0;
        reg_wr(`PTDP_A_IMASK, 32'h00000001);
        run_elem(32'h95090104, 32'h00100000, 32'h000001fc, 16'h0000, s);
        chk(32'(seen_q.size()), 32'h3);
        chk_pkt(0, `PTDP_TC_QWR, 16'h0004, 32'h000001fc, 3'h1, `PTDP_RT_FIRST);
        chk_pkt(1, `PTDP_TC_BWR, 16'h0080, 32'h00000200, 3'h1, `PTDP_RT_FIRST);
        chk_pkt(2, `PTDP_TC_BWR, 16'h0080, 32'h00000280, 3'h1, `PTDP_RT_FIRST);
        chk(32'(s[3:0]), 32'h1);
        chk(32'(IRQ), 32'h1);
        reg_rd(`PTDP_A_ISTAT, s);
        chk(s, 32'h00000001);
        chk(32'(IRQ), 32'h0);
        $display("test paged write finished");
    endtask : t_write

    // Slow take, pending acknowledges, data forwarded to the receive buffer
    task automatic t_read;
        logic [31:0] s;
        pmode = 2'h1;
        pslow = 1'b1;
        reg_wr(`PTDP_A_IMASK, 32'h00000000);
        run_elem(32'h00090008, 32'h00100000, 32'h00000100, 16'h0000, s);
        pslow = 1'b0;
        chk(32'(seen_q.size()), 32'h2);
        chk_pkt(0, `PTDP_TC_QRD, 16'h0004, 32'h00000100, 3'h0, `PTDP_RT_FIRST);
        chk_pkt(1, `PTDP_TC_QRD, 16'h0004, 32'h00000104, 3'h0, `PTDP_RT_FIRST);
        chk(32'(n_arb), 32'h2);
        chk(arb_last, 32'hc0de0001);
        chk(32'(s[3:0]), 32'h1);
        chk(32'(IRQ), 32'h0);
        $display("test paged read finished");
    endtask : t_read

    task automatic t_busy;
        logic [31:0] s;
        pmode = 2'h2;
        run_elem(32'h82090010, 32'h00100002, 32'h00000000, 16'h0010, s);
        chk(32'(seen_q.size()), 32'h3);
        chk_pkt(0, `PTDP_TC_BWR, 16'h0010, 32'h00000000, 3'h0, `PTDP_RT_FIRST);
        chk_pkt(2, `PTDP_TC_BWR, 16'h0010, 32'h00000000, 3'h0, `PTDP_RT_RETRY);
        chk(32'(s[3:0]), 32'h2);
        $display("test busy retry finished");
    endtask : t_busy

    task automatic t_tmo;
        logic [31:0] s;
        pmode = 2'h3;
        run_elem(32'h02090004, 32'h00030000, 32'h00000040, 16'h0004, s);
        chk(32'(seen_q.size()), 32'h1);
        chk(32'(s[3:0]), 32'h4);
        $display("test split timeout finished");
    endtask : t_tmo

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : wrap_up

    // A full run needs a few hundred cycles; this leaves ample margin
    initial begin
        repeat (20000) @(posedge CORE_CLK);
        err_total++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge CORE_CLK);
        SRST <= 1'b0;
        @(posedge CORE_CLK);
        t_reset();
        t_write();
        t_read();
        t_busy();
        t_tmo();
        wrap_up();
    end
endmodule : ptdp_top_bench
